/* File: design/spm_pkg.sv */
// package: shared constants and types of the serial master
package spm_pkg;
    // register offsets on the host bus, added to the base address
    localparam logic [7:0] OFS_STATUS    = 8'h80;
    localparam logic [7:0] OFS_CONTROL   = 8'h84;
    localparam logic [7:0] OFS_SLAVE_SEL = 8'h88;
    localparam logic [7:0] OFS_TX_HOLD   = 8'h8a;
    localparam logic [7:0] OFS_RX_HOLD   = 8'h8e;
    localparam logic [15:0] BASE_ADDR_DEF = 16'h0000;

    // status bit positions
    localparam int ST_DONE     = 7;
    localparam int ST_ERR      = 6;
    localparam int ST_BUSY     = 5;
    localparam int ST_TX_EMPTY = 1;
    localparam int ST_RX_FULL  = 0;

    // control bit positions
    localparam int CT_ENABLE = 7;
    localparam int CT_INT_EN = 6;
    localparam int CT_START  = 5;
    localparam int CT_CPOL   = 4;
    localparam int CT_CPHA   = 3;
    localparam int CT_DIV_HI = 1;
    localparam int CT_DIV_LO = 0;

    // reset values
    localparam logic [7:0] CONTROL_RST   = 8'h00;
    localparam logic [7:0] SLAVE_SEL_RST = 8'h00;
    localparam logic [7:0] HOLD_RST      = 8'h00;
    localparam logic [7:0] SS_N_RST      = 8'hff;

    // input synchroniser width and idle value
    localparam int SYN_W = 22;
    localparam logic [SYN_W-1:0] SYN_RST = 22'h2f0000;

    // serial clock ratios to the system clock
    localparam int SCK_RATIO_2  = 2;
    localparam int SCK_RATIO_4  = 4;
    localparam int SCK_RATIO_8  = 8;
    localparam int SCK_RATIO_16 = 16;
    localparam int EDGES_PER_BYTE = 16;

    typedef enum logic [1:0] {
        HB_IDLE,
        HB_DECODE,
        HB_DATA,
        HB_END
    } spm_host_state_t;

    typedef enum logic {
        EN_IDLE,
        EN_RUN
    } spm_eng_state_t;

    typedef struct packed {
        logic       cpol;
        logic       cpha;
        logic [1:0] div_sel;
    } spm_cfg_t;

    typedef struct packed {
        logic [7:0] rx_byte;
        logic       done;
        logic       busy;
    } spm_eng_out_t;
endpackage

/* File: design/spm_shift_engine.sv */
`timescale 1ns/10ps
// bit engine: serial clock divider and one-byte shifter
module spm_shift_engine (
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    input  wire logic                  abort,
    input  wire spm_pkg::spm_cfg_t     cfg,
    input  wire logic                  load,
    input  wire logic [7:0]            load_byte,
    input  wire logic                  miso,
    output wire logic                  sck,
    output wire logic                  mosi,
    output wire spm_pkg::spm_eng_out_t eng
);
    spm_pkg::spm_eng_state_t state;
    spm_pkg::spm_cfg_t       cfg_q;
    logic [3:0]              half_cnt;
    logic [3:0]              edge_cnt;
    logic [7:0]              tx_sh;
    logic [7:0]              rx_sh;
    logic [7:0]              rx_q;
    logic                    sck_q;
    logic                    mosi_q;
    logic                    done_q;
    logic                    samp_d1;
    logic                    samp_d2;
    logic                    last_d1;
    logic                    last_d2;

    function automatic logic [3:0] half_len(input logic [1:0] sel);
        case (sel)
            2'b00:   half_len = 4'(spm_pkg::SCK_RATIO_2 / 2);
            2'b01:   half_len = 4'(spm_pkg::SCK_RATIO_4 / 2);
            2'b10:   half_len = 4'(spm_pkg::SCK_RATIO_8 / 2);
            default: half_len = 4'(spm_pkg::SCK_RATIO_16 / 2);
        endcase
    endfunction

    wire       run         = state == spm_pkg::EN_RUN;
    wire       tick        = run && (half_cnt == half_len(cfg_q.div_sel) - 4'h1);
    wire       odd_edge    = edge_cnt[0];
    wire       sample_edge = tick && (cfg_q.cpha ? odd_edge : !odd_edge);
    wire       drive_edge  = tick && (cfg_q.cpha ? !odd_edge : odd_edge);
    wire       last_edge   = tick && (edge_cnt == 4'(spm_pkg::EDGES_PER_BYTE - 1));
    // miso comes through two sync flops: sample it two cycles after the edge
    wire       drain       = last_d1 || last_d2;
    wire       start_byte  = load && !run && !drain;
    wire [7:0] next_rx     = samp_d2 ? {rx_sh[6:0], miso} : rx_sh;

    always_ff @(posedge sys_clk) begin
        if (!resetn || abort) begin
            state    <= spm_pkg::EN_IDLE;
            cfg_q    <= '0;
            half_cnt <= 4'h0;
            edge_cnt <= 4'h0;
            tx_sh    <= 8'h00;
            rx_sh    <= 8'h00;
            sck_q    <= 1'b0;
            mosi_q   <= 1'b0;
            done_q   <= 1'b0;
            samp_d1  <= 1'b0;
            samp_d2  <= 1'b0;
            last_d1  <= 1'b0;
            last_d2  <= 1'b0;
        end else begin
            done_q  <= last_d2;
            rx_sh   <= next_rx;
            samp_d1 <= sample_edge;
            samp_d2 <= samp_d1;
            last_d1 <= last_edge;
            last_d2 <= last_d1;
            if (start_byte) begin
                state    <= spm_pkg::EN_RUN;
                cfg_q    <= cfg;
                half_cnt <= 4'h0;
                edge_cnt <= 4'h0;
                sck_q    <= cfg.cpol;
                if (cfg.cpha) begin
                    tx_sh <= load_byte;
                end else begin
                    mosi_q <= load_byte[7];
                    tx_sh  <= {load_byte[6:0], 1'b0};
                end
            end else if (run) begin
                half_cnt <= tick ? 4'h0 : half_cnt + 4'h1;
                if (tick) begin
                    edge_cnt <= edge_cnt + 4'h1;
                    sck_q    <= ~sck_q;
                end
                if (drive_edge) begin
                    mosi_q <= tx_sh[7];
                    tx_sh  <= {tx_sh[6:0], 1'b0};
                end
                if (last_edge)
                    state <= spm_pkg::EN_IDLE;
            end else begin
                sck_q <= cfg.cpol;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn || abort)
            rx_q <= 8'h00;
        else if (last_d2)
            rx_q <= next_rx;
    end

    assign sck  = sck_q;
    assign mosi = mosi_q;
    assign eng  = '{rx_byte: rx_q, done: done_q, busy: run || drain};

    a_sck_idle_level: assert property (@(posedge sys_clk) disable iff (!resetn || abort)
        (!run && !load) |=> (sck_q == $past(cfg.cpol)))
        else $error("serial clock not at idle level");

    a_byte_length: assert property (@(posedge sys_clk) disable iff (!resetn || abort)
        (start_byte && cfg.div_sel == 2'b00) |-> ##19 (done_q && !run))
        else $error("byte did not end after sixteen edges");

    a_div_sixteen: assert property (@(posedge sys_clk) disable iff (!resetn || abort)
        (tick && cfg_q.div_sel == 2'b11 && !last_edge) |=> (!tick)[*7] ##1 tick)
        else $error("divide by sixteen half period wrong");

    a_mosi_first_bit: assert property (@(posedge sys_clk) disable iff (!resetn || abort)
        (start_byte && !cfg.cpha) |=> (mosi_q == $past(load_byte[7])))
        else $error("first bit not presented before first edge");
endmodule

/* File: design/spm_spi_master.sv */
`timescale 1ns/10ps
// top: host bus port, registers and slave selects of the serial master
module spm_spi_master #(
    parameter logic [15:0] BASE_ADDR = spm_pkg::BASE_ADDR_DEF
) (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic [7:0] addr_hi,
    input  wire logic [7:0] ad_in,
    output wire logic [7:0] ad_out,
    output wire logic       ad_oe,
    input  wire logic       ale_n,
    input  wire logic       prog_fetch_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    output wire logic       int_n,
    output wire logic       tx_hold_empty,
    output wire logic       rx_hold_full,
    input  wire logic       contention_n,
    output wire logic [7:0] slave_sel_n,
    output wire logic       sck,
    output wire logic       mosi,
    input  wire logic       miso
);
    if (BASE_ADDR > 16'hff71) begin : g_base_check
        $error("base address leaves no room for the register block");
    end

    // two-flop synchroniser for every pin input except sys_clk and resetn
    logic [spm_pkg::SYN_W-1:0] syn_1;
    logic [spm_pkg::SYN_W-1:0] syn_2;

    wire [spm_pkg::SYN_W-1:0] syn_raw = {contention_n, miso, prog_fetch_n,
                                         wr_n, rd_n, ale_n, ad_in, addr_hi};

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            syn_1 <= spm_pkg::SYN_RST;
            syn_2 <= spm_pkg::SYN_RST;
        end else begin
            syn_1 <= syn_raw;
            syn_2 <= syn_1;
        end
    end

    wire       contention_s = syn_2[21];
    wire       miso_s       = syn_2[20];
    wire       fetch_s      = syn_2[19];
    wire       wr_s         = syn_2[18];
    wire       rd_s         = syn_2[17];
    wire       ale_s        = syn_2[16];
    wire [7:0] ad_s         = syn_2[15:8];
    wire [7:0] hi_s         = syn_2[7:0];

    // host bus cycle tracking
    spm_pkg::spm_host_state_t hstate;
    spm_pkg::spm_host_state_t next_state;
    logic [15:0]              cyc_addr;
    logic                     rd_q;
    logic [7:0]               ad_out_q;

    function automatic logic reg_hit(input logic [15:0] a, input logic [7:0] ofs);
        reg_hit = a == 16'(BASE_ADDR + {8'h00, ofs});
    endfunction

    wire sel_status  = reg_hit(cyc_addr, spm_pkg::OFS_STATUS);
    wire sel_control = reg_hit(cyc_addr, spm_pkg::OFS_CONTROL);
    wire sel_slave   = reg_hit(cyc_addr, spm_pkg::OFS_SLAVE_SEL);
    wire sel_tx      = reg_hit(cyc_addr, spm_pkg::OFS_TX_HOLD);
    wire sel_rx      = reg_hit(cyc_addr, spm_pkg::OFS_RX_HOLD);
    wire any_sel     = sel_status | sel_control | sel_slave | sel_tx | sel_rx;
    wire strobe      = !rd_s || !wr_s;

    always_comb begin
        next_state = hstate;
        case (hstate)
            spm_pkg::HB_IDLE: begin
                if (!ale_s && fetch_s)
                    next_state = spm_pkg::HB_DECODE;
            end
            spm_pkg::HB_DECODE: begin
                if (ale_s)
                    next_state = spm_pkg::HB_IDLE;
                else if (!fetch_s)
                    next_state = spm_pkg::HB_END;
                else if (strobe && any_sel)
                    next_state = spm_pkg::HB_DATA;
                else if (strobe)
                    next_state = spm_pkg::HB_END;
            end
            spm_pkg::HB_DATA: begin
                if (!strobe || !fetch_s)
                    next_state = spm_pkg::HB_END;
            end
            spm_pkg::HB_END: begin
                if (ale_s)
                    next_state = spm_pkg::HB_IDLE;
            end
            default: next_state = spm_pkg::HB_IDLE;
        endcase
    end

    wire enter_data = hstate == spm_pkg::HB_DECODE && next_state == spm_pkg::HB_DATA;
    wire host_wr    = enter_data && !wr_s;
    wire host_rd    = enter_data && wr_s;
    wire wr_status  = host_wr && sel_status;
    wire wr_control = host_wr && sel_control;
    wire wr_slave   = host_wr && sel_slave;
    wire wr_tx      = host_wr && sel_tx;
    wire rd_rx      = host_rd && sel_rx;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            hstate   <= spm_pkg::HB_IDLE;
            cyc_addr <= 16'h0000;
        end else begin
            hstate <= next_state;
            if (hstate == spm_pkg::HB_IDLE && next_state == spm_pkg::HB_DECODE)
                cyc_addr <= {hi_s, ad_s};
        end
    end

    // device registers
    logic [7:0]            control;
    logic [7:0]            slave_sel;
    logic [7:0]            tx_hold_reg;
    logic [7:0]            rx_hold_reg;
    logic                  tx_empty_q;
    logic                  rx_full_q;
    logic                  spi_err;
    logic [7:0]            ss_n_q;
    logic                  int_n_q;
    logic [7:0]            status_val;
    spm_pkg::spm_eng_out_t eng;

    wire abort    = !contention_s;
    wire enable   = control[spm_pkg::CT_ENABLE];
    wire int_en   = control[spm_pkg::CT_INT_EN];
    wire start    = control[spm_pkg::CT_START];
    wire eng_load = enable && start && !tx_empty_q && !eng.busy && !wr_tx && !abort;
    wire ss_on    = enable && !abort && (start || eng.busy);

    wire spm_pkg::spm_cfg_t cfg = '{cpol: control[spm_pkg::CT_CPOL],
                                    cpha: control[spm_pkg::CT_CPHA],
                                    div_sel: control[spm_pkg::CT_DIV_HI:spm_pkg::CT_DIV_LO]};

    always_comb begin
        status_val                       = 8'h00;
        status_val[spm_pkg::ST_DONE]     = !eng.busy;
        status_val[spm_pkg::ST_ERR]      = spi_err;
        status_val[spm_pkg::ST_BUSY]     = eng.busy;
        status_val[spm_pkg::ST_TX_EMPTY] = tx_empty_q;
        status_val[spm_pkg::ST_RX_FULL]  = rx_full_q;
    end

    wire [7:0] read_data = sel_status  ? status_val  :
                           sel_control ? control     :
                           sel_slave   ? slave_sel   :
                           sel_tx      ? tx_hold_reg :
                           sel_rx      ? rx_hold_reg : 8'h00;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rd_q     <= 1'b0;
            ad_out_q <= 8'h00;
        end else if (enter_data) begin
            rd_q     <= wr_s;
            ad_out_q <= read_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn)
            control <= spm_pkg::CONTROL_RST;
        else if (abort)
            control[spm_pkg::CT_START] <= 1'b0;
        else if (wr_control)
            control <= ad_s;
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            slave_sel   <= spm_pkg::SLAVE_SEL_RST;
            tx_hold_reg <= spm_pkg::HOLD_RST;
        end else begin
            if (wr_slave)
                slave_sel <= ad_s;
            if (wr_tx)
                tx_hold_reg <= ad_s;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn || abort)
            tx_empty_q <= 1'b1;
        else if (eng_load)
            tx_empty_q <= 1'b1;
        else if (wr_tx)
            tx_empty_q <= 1'b0;
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rx_hold_reg <= spm_pkg::HOLD_RST;
            rx_full_q   <= 1'b0;
        end else if (eng.done) begin
            rx_hold_reg <= eng.rx_byte;
            rx_full_q   <= 1'b1;
        end else if (rd_rx) begin
            rx_full_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn)
            spi_err <= 1'b0;
        else if (abort)
            spi_err <= 1'b1;
        else if (wr_status && !ad_s[spm_pkg::ST_ERR])
            spi_err <= 1'b0;
    end

    wire int_cause = spi_err || (tx_empty_q && start) || (rx_full_q && !start);

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ss_n_q  <= spm_pkg::SS_N_RST;
            int_n_q <= 1'b1;
        end else begin
            ss_n_q  <= ~(slave_sel & {8{ss_on}});
            int_n_q <= !(int_en && int_cause);
        end
    end

    spm_shift_engine u_engine (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .abort     (abort),
        .cfg       (cfg),
        .load      (eng_load),
        .load_byte (tx_hold_reg),
        .miso      (miso_s),
        .sck       (sck),
        .mosi      (mosi),
        .eng       (eng)
    );

    assign ad_out        = ad_out_q;
    assign ad_oe         = hstate == spm_pkg::HB_DATA && rd_q && fetch_s;
    assign int_n         = int_n_q;
    assign tx_hold_empty = tx_empty_q;
    assign rx_hold_full  = rx_full_q;
    assign slave_sel_n   = ss_n_q;

    a_ss_idle_high: assert property (@(posedge sys_clk) disable iff (!resetn)
        !ss_on |=> slave_sel_n == 8'hff)
        else $error("slave select active outside a transaction");

    a_int_off_disabled: assert property (@(posedge sys_clk) disable iff (!resetn)
        !int_en |=> int_n)
        else $error("interrupt driven while disabled");

    a_contention_abort: assert property (@(posedge sys_clk) disable iff (!resetn)
        (abort && int_en) |=> (spi_err && !start && !eng.busy) ##1 !int_n)
        else $error("contention did not abort and interrupt");

    a_tx_empty_load: assert property (@(posedge sys_clk) disable iff (!resetn)
        eng_load |=> tx_hold_empty && eng.busy)
        else $error("transmit empty not raised on load");

    a_rx_full_done: assert property (@(posedge sys_clk) disable iff (!resetn)
        eng.done |=> rx_hold_full && rx_hold_reg == $past(eng.rx_byte))
        else $error("receive byte not captured");

    a_tx_int_running: assert property (@(posedge sys_clk) disable iff (!resetn)
        (int_en && start && tx_empty_q) |=> !int_n)
        else $error("missing transmit empty interrupt");

    a_no_mid_int: assert property (@(posedge sys_clk) disable iff (!resetn)
        (int_en && start && !tx_empty_q && !spi_err) |=> int_n)
        else $error("interrupt raised for an intermediate byte");

    a_rx_int_final: assert property (@(posedge sys_clk) disable iff (!resetn)
        (int_en && !start && rx_full_q) |=> !int_n)
        else $error("missing final byte interrupt");

    a_fetch_no_drive: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!fetch_s && hstate == spm_pkg::HB_DECODE) |=> !ad_oe)
        else $error("bus driven during program fetch");

    a_read_drive: assert property (@(posedge sys_clk) disable iff (!resetn)
        (host_rd && !rd_s) |=> ad_oe && ad_out == $past(read_data))
        else $error("read data not driven");
endmodule

/* File: sim/spm_slave_model.sv */
`timescale 1ns/10ps
// far-side model: one serial slave in any of the four clock modes
module spm_slave_model (
    input  wire logic       clk,
    input  wire logic       ss_n,
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       cpol,
    input  wire logic       cpha,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic [7:0]      rx_byte
);
    logic [7:0] sh;
    logic       lead;
    initial begin
        sh = 8'h00;
        miso = 1'b0;
        rx_byte = 8'h00;
    end
    // released line flips every cycle
    always @(posedge clk) begin
        if (ss_n) miso <= ~miso;
    end
    always @(negedge ss_n) begin
        sh = tx_byte;
        rx_byte = 8'h00;
        if (!cpha) miso = sh[7];
    end
    always @(sck) begin
        lead = (sck !== cpol);
        if (!ss_n && (lead ^ cpha)) rx_byte = {rx_byte[6:0], mosi};
        else if (!ss_n && cpha) begin
            miso = sh[7];
            sh = sh << 1;
        end else if (!ss_n) begin
            sh = sh << 1;
            miso = sh[7];
        end
    end
endmodule

/* File: sim/spm_spi_master_tb_top.sv */
`timescale 1ns/10ps
// bench: host bus cycles, transfers in all modes, contention and fetch cases
module spm_spi_master_tb_top;
    logic       sys_clk, resetn, ale_n, prog_fetch_n, rd_n, wr_n, contention_n;
    logic       ad_oe, int_n, tx_hold_empty, rx_hold_full, sck, mosi, miso;
    logic [7:0] addr_hi, host_ad, float_pat, ad_out, slave_sel_n, s_tx, s_rx;
    logic       host_on, s_cpol, s_cpha, sck_q, ie, oe;
    logic [7:0] seed, q, rnd, txb;
    logic [2:0] sel;
    wire  [7:0] ad_in = ad_oe ? ad_out : (host_on ? host_ad : float_pat);
    int         n_mismatch, check_count, n_edge, half_bad, hp, exp_half, cyc;

    spm_spi_master dut (.sys_clk(sys_clk), .resetn(resetn), .addr_hi(addr_hi),
        .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .ale_n(ale_n),
        .prog_fetch_n(prog_fetch_n), .rd_n(rd_n), .wr_n(wr_n), .int_n(int_n),
        .tx_hold_empty(tx_hold_empty), .rx_hold_full(rx_hold_full),
        .contention_n(contention_n), .slave_sel_n(slave_sel_n), .sck(sck),
        .mosi(mosi), .miso(miso));
    spm_slave_model slv (.clk(sys_clk), .ss_n(slave_sel_n[sel]), .sck(sck), .mosi(mosi),
        .cpol(s_cpol), .cpha(s_cpha), .tx_byte(s_tx), .miso(miso), .rx_byte(s_rx));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    function automatic logic [7:0] nxt();
        seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        return seed;
    endfunction

    function automatic logic [7:0] mk_ctl(input logic i, st, pol, pha, input logic [1:0] dv);
        logic [7:0] c;
        c = {6'h00, dv};
        c[spm_pkg::CT_ENABLE] = 1'b1;
        c[spm_pkg::CT_INT_EN] = i;
        c[spm_pkg::CT_START] = st;
        c[spm_pkg::CT_CPOL] = pol;
        c[spm_pkg::CT_CPHA] = pha;
        return c;
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // one host cycle: address phase, strobe held 8 cycles, release
    task automatic bus(input bit wr, input logic [7:0] a, d, input logic pf);
        @(posedge sys_clk);
        ale_n <= 1'b0;
        addr_hi <= 8'h00;
        host_ad <= a;
        host_on <= 1'b1;
        prog_fetch_n <= pf;
        repeat (3) @(posedge sys_clk);
        if (wr) begin
            host_ad <= d;
            wr_n <= 1'b0;
        end else begin
            host_on <= 1'b0;
            rd_n <= 1'b0;
        end
        oe = 1'b0;
        q = 8'h00;
        repeat (8) begin
            @(posedge sys_clk);
            if (ad_oe === 1'b1 && !oe) q = ad_out;
            if (ad_oe === 1'b1) oe = 1'b1;
        end
        wr_n <= 1'b1;
        rd_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        ale_n <= 1'b1;
        prog_fetch_n <= 1'b1;
        host_on <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask

    always @(posedge sys_clk) begin
        float_pat <= ~float_pat;
        hp = hp + 1;
        if (sck !== sck_q) begin
            if (n_edge != 0 && hp != exp_half) half_bad = half_bad + 1;
            n_edge = n_edge + 1;
            hp = 0;
        end
        sck_q = sck;
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end

    initial begin
        {resetn, ale_n, prog_fetch_n, rd_n, wr_n, contention_n} = 6'h1f;
        {addr_hi, host_ad, host_on, float_pat, seed} = {17'h0, 8'h5a, 8'h0c};
        {s_cpol, s_cpha, sck_q, sel, s_tx, exp_half} = {3'h0, 3'h0, 8'h00, 32'd1};
        {n_mismatch, check_count, n_edge, half_bad, hp, cyc} = '0;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk(slave_sel_n, 8'hff);
        chk({ad_oe, int_n, tx_hold_empty, rx_hold_full, 4'h0}, 8'h60);
        bus(0, spm_pkg::OFS_CONTROL, 8'h00, 1'b1);
        chk(q, spm_pkg::CONTROL_RST);
        for (int k = 0; k < 8; k++) begin
            rnd = nxt();
            sel = rnd[2:0];
            {s_cpol, s_cpha} = k[2:1];
            ie = rnd[5] | (k == 0);
            s_tx = nxt();
            txb = (k == 1) ? 8'h80 : nxt();
            bus(1, spm_pkg::OFS_SLAVE_SEL, 8'h01 << sel, 1'b1);
            bus(1, spm_pkg::OFS_CONTROL, mk_ctl(ie, 0, s_cpol, s_cpha, k[1:0]), 1'b1);
            bus(1, spm_pkg::OFS_TX_HOLD, txb, 1'b1);
            chk({7'h00, tx_hold_empty}, 8'h00);
            n_edge = 0;
            half_bad = 0;
            exp_half = 1 << k[1:0];
            bus(1, spm_pkg::OFS_CONTROL, mk_ctl(ie, 1, s_cpol, s_cpha, k[1:0]), 1'b1);
            chk(slave_sel_n, ~(8'h01 << sel));
            chk({7'h00, tx_hold_empty}, 8'h01);
            chk({7'h00, int_n}, {7'h00, ~ie});
            for (int w = 0; w < 400 && rx_hold_full !== 1'b1; w++) @(posedge sys_clk);
            chk(n_edge[7:0], 8'h10);
            chk(half_bad[7:0], 8'h00);
            chk(s_rx, txb);
            bus(1, spm_pkg::OFS_CONTROL, mk_ctl(ie, 0, s_cpol, s_cpha, k[1:0]), 1'b1);
            chk({6'h00, int_n, rx_hold_full}, {6'h00, ~ie, 1'b1});
            chk(slave_sel_n, 8'hff);
            chk({7'h00, sck}, {7'h00, s_cpol});
            bus(0, spm_pkg::OFS_RX_HOLD, 8'h00, 1'b1);
            chk(q, s_tx);
            chk({6'h00, rx_hold_full, int_n}, 8'h01);
        end
        sel = 3'h0;
        {s_cpol, s_cpha} = 2'b00;
        bus(1, spm_pkg::OFS_SLAVE_SEL, 8'h01, 1'b1);
        bus(1, spm_pkg::OFS_CONTROL, mk_ctl(1, 0, 0, 0, 2'h3), 1'b1);
        bus(1, spm_pkg::OFS_TX_HOLD, nxt(), 1'b1);
        bus(1, spm_pkg::OFS_CONTROL, mk_ctl(1, 1, 0, 0, 2'h3), 1'b1);
        repeat (20) @(posedge sys_clk);
        contention_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        contention_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk(slave_sel_n, 8'hff);
        chk({5'h00, sck, int_n, tx_hold_empty}, 8'h01);
        bus(0, spm_pkg::OFS_STATUS, 8'h00, 1'b1);
        chk({7'h00, q[spm_pkg::ST_ERR]}, 8'h01);
        bus(1, spm_pkg::OFS_STATUS, 8'h00, 1'b1);
        chk({7'h00, int_n}, 8'h01);
        bus(1, spm_pkg::OFS_CONTROL, 8'h5b, 1'b0);
        bus(0, spm_pkg::OFS_CONTROL, 8'h00, 1'b1);
        chk(q, mk_ctl(1, 0, 0, 0, 2'h3));
        bus(0, spm_pkg::OFS_CONTROL, 8'h00, 1'b0);
        chk({7'h00, oe}, 8'h00);
        bus(0, 8'h81, 8'h00, 1'b1);
        chk({7'h00, oe}, 8'h00);
        results();
    end
endmodule
